// [core/eidc_top.sv]
// external interrupt controller: source select, debounce, polarity, pending, masks
`timescale 1ns/1ps
// Functional notes
// - a line uses its primary pad when selected, else, where HAS_SEC is set, its secondary pad when that is selected.
// - every line can raise a wakeup request to restart the system clock.
// - the filter output follows the input only after it held stable for one tick more than the programmed period.
// - new debounce period or enable settings take effect at the next slow tick or later.
// - polarity is held in the system clock domain and acts at once.
// - one read-only pending bit per line; ack writes of one clear edge requests.
// - each line has a mask bit, one blocks the request, all reset to one.
// - mask set and clear strobes change only the bits written as one.
// - a separate wakeup mask per line, reset to one, with its own set and clear.
module eidc_top
	import eidc_pkg::*;
#(
	parameter int LINES   = eidc_pkg::NUM_LINES,
	parameter int CNT_W   = eidc_pkg::DB_CNT_W,
	parameter int DIV     = eidc_pkg::SLOW_DIV
) (
	// clock and reset
	input  wire logic                        sys_clk_in,
	input  wire logic                        rst_n_in,
	// pads, already inverted, and function selects
	input  wire logic [eidc_pkg::NUM_PAD_LINES-1:0] pad_pri_in,
	input  wire logic [eidc_pkg::NUM_PAD_LINES-1:0] pad_sec_in,
	input  wire logic [eidc_pkg::NUM_PAD_LINES*eidc_pkg::FSEL_W-1:0] pad_pri_fsel_in,
	input  wire logic [eidc_pkg::NUM_PAD_LINES*eidc_pkg::FSEL_W-1:0] pad_sec_fsel_in,
	// internal peripheral sources
	input  wire logic [4:0]                  keypad_column_inputs_in,
	input  wire logic [10:0]                 periph_src_in,
	// configuration
	input  wire logic [31:0]                 db_en_in,
	input  wire logic [CNT_W-1:0]            db_period_in,
	input  wire logic [31:0]                 polarity_in,
	input  wire logic [31:0]                 edge_sens_in,
	// strobes: one bit per line, one cycle
	input  wire logic [31:0]                 irq_ack_bits_in,
	input  wire logic [31:0]                 irq_mask_set_in,
	input  wire logic [31:0]                 irq_mask_clear_in,
	input  wire logic [31:0]                 wake_mask_set_in,
	input  wire logic [31:0]                 wake_mask_clear_in,
	// status and requests
	output logic [31:0]                      irq_pending_bits_out,
	output logic [31:0]                      irq_mask_out,
	output logic [31:0]                      wake_mask_out,
	output logic                             irq_out,
	output logic                             wake_req_out
);
	import eidc_pkg::*;
	localparam int ASYNC_W = 2 * NUM_PAD_LINES + 16;

	typedef struct packed {
		logic [ASYNC_W-1:0] sync1;
		logic [ASYNC_W-1:0] sync2;
		logic [15:0]      div;
		logic             tick;
		logic [31:0]      db_en;
		logic [CNT_W-1:0] period;
		logic [31:0]      pol;
		logic [31:0]      lvl_d;
		logic [31:0]      pend;
		logic [31:0]      mask;
		logic [31:0]      wmask;
		logic             irq;
		logic             wake;
	} eidc_st_t;

	eidc_st_t    cur;
	eidc_st_t    next_cur;
	logic [31:0] src_raw;
	logic [31:0] filt;
	logic [31:0] act;
	logic [31:0] ack_eff;
	logic [ASYNC_W-1:0] async_in;

	function automatic logic [FSEL_W-1:0] fsel(input logic [NUM_PAD_LINES*FSEL_W-1:0] v,
			input int i);
		fsel = v[i*FSEL_W +: FSEL_W];
	endfunction : fsel

	// ==========================================
	// input synchroniser
	// async sources are flopped before any mux logic reads them
	assign async_in = {periph_src_in, keypad_column_inputs_in, pad_sec_in, pad_pri_in};

	// ==========================================
	// source select
	always_comb begin
		src_raw = '0;
		for (int i = 0; i < NUM_PAD_LINES; i++) begin
			if (fsel(pad_pri_fsel_in, i) == PRI_SEL[i])
				src_raw[i] = cur.sync2[i];
			else if (HAS_SEC[i] && fsel(pad_sec_fsel_in, i) == SEC_SEL[i])
				src_raw[i] = cur.sync2[NUM_PAD_LINES+i];
		end
		src_raw[20] = |cur.sync2[2*NUM_PAD_LINES +: 5];
		src_raw[31:21] = cur.sync2[ASYNC_W-1 -: 11];
	end

	// ==========================================
	// debounce filters
	for (genvar g = 0; g < LINES; g++) begin : g_db
		eidc_debounce #(.CNT_W(CNT_W)) u_db (
			.sys_clk_in (sys_clk_in),
			.rst_n_in   (rst_n_in),
			.tick_in    (cur.tick),
			.en_in      (cur.db_en[g]),
			.period_in  (cur.period),
			.raw_in     (src_raw[g]),
			.filt_out   (filt[g])
		);
	end

	assign act = filt ^ cur.pol;

	// acks that clear: edge lines with no new edge this cycle
	assign ack_eff = irq_ack_bits_in & edge_sens_in & ~(act & ~cur.lvl_d);

	// ==========================================
	// state update
	always_comb begin
		next_cur = cur;
		next_cur.sync1 = async_in;
		next_cur.sync2 = cur.sync1;
		next_cur.tick = 1'b0;
		if (cur.div >= 16'(DIV - 1)) begin
			next_cur.div = '0;
			next_cur.tick = 1'b1;
		end else begin
			next_cur.div = cur.div + 16'h0001;
		end
		if (cur.tick) begin
			next_cur.db_en = db_en_in;
			next_cur.period = db_period_in;
		end
		next_cur.pol = polarity_in;
		next_cur.lvl_d = act;
		// ack clears edge, new edge wins
		for (int i = 0; i < 32; i++) begin
			if (edge_sens_in[i]) begin
				if (act[i] && !cur.lvl_d[i])
					next_cur.pend[i] = 1'b1;
				else if (irq_ack_bits_in[i])
					next_cur.pend[i] = 1'b0;
			end else begin
				next_cur.pend[i] = act[i];
			end
		end
		next_cur.mask = (cur.mask | irq_mask_set_in) & ~irq_mask_clear_in;
		next_cur.wmask = (cur.wmask | wake_mask_set_in) & ~wake_mask_clear_in;
		next_cur.irq = |(cur.pend & ~cur.mask);
		next_cur.wake = |(cur.pend & ~cur.wmask);
	end

	// masks come out of reset closed
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur <= '0;
			cur.mask <= MASK_RESET;
			cur.wmask <= WMASK_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign irq_pending_bits_out = cur.pend;
	assign irq_mask_out = cur.mask;
	assign wake_mask_out = cur.wmask;
	assign irq_out = cur.irq;
	assign wake_req_out = cur.wake;

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_mask_set_now: assert property (|irq_mask_set_in && !(|irq_mask_clear_in)
		|=> ((irq_mask_out & $past(irq_mask_set_in)) == $past(irq_mask_set_in)))
		else $error("mask set lost");
	a_mask_clr_now: assert property (|irq_mask_clear_in
		|=> ((irq_mask_out & $past(irq_mask_clear_in)) == 32'h00000000))
		else $error("mask clear lost");
	a_wmask_set_now: assert property (|wake_mask_set_in && !(|wake_mask_clear_in)
		|=> ((wake_mask_out & $past(wake_mask_set_in)) == $past(wake_mask_set_in)))
		else $error("wake mask set lost");
	a_wmask_clr_now: assert property (|wake_mask_clear_in
		|=> ((wake_mask_out & $past(wake_mask_clear_in)) == 32'h00000000))
		else $error("wake mask clear lost");
	a_irq_masked_off: assert property (irq_mask_out == 32'hFFFFFFFF
		|=> !irq_out) else $error("masked irq seen");
	a_irq_follows_pend: assert property (|(irq_pending_bits_out & ~irq_mask_out)
		|=> irq_out) else $error("irq missing");
	a_wake_follows: assert property (|(irq_pending_bits_out & ~wake_mask_out)
		|=> wake_req_out) else $error("wake missing");
	a_ack_clears: assert property (|ack_eff
		|=> ((irq_pending_bits_out & $past(ack_eff)) == 32'h00000000))
		else $error("ack did not clear");
	a_cfg_on_tick: assert property (($changed(cur.period) || $changed(cur.db_en))
		|-> $past(cur.tick)) else $error("setting changed off tick");
	a_sync_two: assert property (cur.sync2 == $past(async_in, 2)
		|| !$past(rst_n_in, 2)) else $error("sync depth wrong");

	// main scenarios
	c_irq_raised: cover property ($rose(irq_out));
	c_wake_raised: cover property ($rose(wake_req_out));
	c_ack_seen: cover property (|(irq_ack_bits_in & irq_pending_bits_out));
	c_edge_acked: cover property (|ack_eff);
	c_db_enabled: cover property (cur.tick && (cur.db_en != 32'h00000000));

endmodule : eidc_top

// [core/eidc_pkg.sv]
// constants and types for the external interrupt debounce controller
package eidc_pkg;

	// ==========================================
	// line counts and field widths
	localparam int NUM_LINES     = 32;
	localparam int NUM_PAD_LINES = 20;
	localparam int FSEL_W        = 3;
	localparam int DB_CNT_W      = 11;

	// ==========================================
	// reset values
	localparam logic [31:0] MASK_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] WMASK_RESET = 32'hFFFFFFFF;

	// ==========================================
	// pad function codes: primary then secondary
	localparam logic [FSEL_W-1:0] PRI_SEL [NUM_PAD_LINES] = '{
		3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h3, 3'h3, 3'h2, 3'h2};
	localparam logic [FSEL_W-1:0] SEC_SEL [NUM_PAD_LINES] = '{
		3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h0, 3'h4,
		3'h5, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
	localparam logic [NUM_PAD_LINES-1:0] HAS_SEC = 20'h0FE78;

	// ==========================================
	// slow clock timing
	localparam int SLOW_HZ  = 32768;
	localparam int SYS_HZ   = 20000000;
	localparam int SLOW_DIV = SYS_HZ / SLOW_HZ;

	// debounce filter state
	typedef enum logic [0:0] {
		EIDC_DB_IDLE = 1'b0,
		EIDC_DB_WAIT = 1'b1
	} eidc_db_state_t;

endpackage : eidc_pkg

// [core/eidc_debounce.sv]
// one-line debounce filter stepped by the slow clock tick
`timescale 1ns/1ps
module eidc_debounce
	import eidc_pkg::*;
#(
	parameter int CNT_W = eidc_pkg::DB_CNT_W
) (
	// clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	// slow tick and settings
	input  wire logic             tick_in,
	input  wire logic             en_in,
	input  wire logic [CNT_W-1:0] period_in,
	// synchronised source and filtered result
	input  wire logic             raw_in,
	output logic                  filt_out
);
	import eidc_pkg::*;

	typedef struct packed {
		eidc_db_state_t   st;
		logic [CNT_W-1:0] cnt;
		logic             filt;
	} eidc_db_t;

	eidc_db_t cur;
	eidc_db_t next_cur;

	// ==========================================
	// filter
	always_comb begin
		next_cur = cur;
		if (!en_in) begin
			next_cur.st = EIDC_DB_IDLE;
			next_cur.cnt = '0;
			if (tick_in)
				next_cur.filt = raw_in;
		end else if (raw_in == cur.filt) begin
			next_cur.st = EIDC_DB_IDLE;
			next_cur.cnt = '0;
		end else if (tick_in) begin
			next_cur.st = EIDC_DB_WAIT;
			if (cur.cnt >= period_in) begin
				next_cur.filt = raw_in;
				next_cur.cnt = '0;
				next_cur.st = EIDC_DB_IDLE;
			end else begin
				next_cur.cnt = cur.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cur <= '{st: EIDC_DB_IDLE, cnt: '0, filt: 1'b0};
		else
			cur <= next_cur;
	end

	assign filt_out = cur.filt;

	// ==========================================
	// checks
	// filter moves on tick only
	a_filt_on_tick: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$changed(filt_out) |-> $past(tick_in)) else $error("filter moved off tick");

endmodule : eidc_debounce

// [dv/eidc_pad_model.sv]
// pad model: raw pad levels seen through the input inversion
`timescale 1ns/1ps
module eidc_pad_model (
	// raw pads and inversion setting
	input  wire logic [19:0] pad_raw_in,
	input  wire logic [19:0] pad_input_invert_in,
	// levels handed to the controller
	output logic      [19:0] pad_out
);
	// pads reach the controller after inversion
	assign pad_out = pad_raw_in ^ pad_input_invert_in;
endmodule : eidc_pad_model

// [dv/tb_top.sv]
// self-checking bench for the external interrupt debounce controller
`timescale 1ns/1ps
module tb_top;
	import eidc_pkg::*;
	localparam int DV  = 8;
	localparam int PER = 2;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [19:0] raw_pri = '0, raw_sec = '0, inv = '0;
	logic [19:0] pad_pri, pad_sec;
	logic [59:0] fsel_pri = '0, fsel_sec = '0;
	logic [4:0]  kcol = '0;
	logic [10:0] periph = '0;
	logic [10:0] db_per = 11'h002;
	logic [31:0] db_en = '0, pol = '0, edge_s = '0, em, ew, r;
	logic [31:0] ack = '0, mset = '0, mclr = '0, wset = '0, wclr = '0;
	logic [31:0] pend, mask, wmask;
	logic        irq, wake;
	int          errors = 0, num_checks = 0;

	eidc_pad_model i_pad_pri (.pad_raw_in(raw_pri), .pad_input_invert_in(inv), .pad_out(pad_pri));
	eidc_pad_model i_pad_sec (.pad_raw_in(raw_sec), .pad_input_invert_in(inv), .pad_out(pad_sec));
	eidc_top #(.DIV(DV)) i_eidc_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.pad_pri_in(pad_pri), .pad_sec_in(pad_sec), .pad_pri_fsel_in(fsel_pri),
		.pad_sec_fsel_in(fsel_sec), .keypad_column_inputs_in(kcol), .periph_src_in(periph),
		.db_en_in(db_en), .db_period_in(db_per), .polarity_in(pol), .edge_sens_in(edge_s),
		.irq_ack_bits_in(ack), .irq_mask_set_in(mset), .irq_mask_clear_in(mclr),
		.wake_mask_set_in(wset), .wake_mask_clear_in(wclr), .irq_pending_bits_out(pend),
		.irq_mask_out(mask), .wake_mask_out(wmask), .irq_out(irq), .wake_req_out(wake));

	always #25 sys_clk_in = ~sys_clk_in;

	// ==========================================
	// helpers
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : cyc

	task automatic wait_pend(input int ln, input logic v, input int lim);
		int k;
		k = 0;
		while (pend[ln] !== v && k < lim) begin
			cyc(1);
			k++;
		end
		if (pend[ln] !== v) begin
			errors++;
			$display("BAD wait_pend exp %h seen %h", v, pend[ln]);
			complete_run();
		end
	endtask : wait_pend

	// strobe one of ack, mask set/clear, wake set/clear for one cycle
	task automatic pulse(input int s, input logic [31:0] v);
		@(posedge sys_clk_in);
		case (s)
			0: ack <= v;
			1: mset <= v;
			2: mclr <= v;
			3: wset <= v;
			default: wclr <= v;
		endcase
		@(posedge sys_clk_in);
		{ack, mset, mclr, wset, wclr} <= '0;
		cyc(1);
	endtask : pulse

	task automatic set_src(input int ln, input logic v);
		@(posedge sys_clk_in);
		if (ln < 20) begin
			raw_pri[ln] <= v ^ inv[ln];
		end else if (ln == 20) begin
			kcol <= v ? 5'(1 << $urandom_range(4)) : 5'h00;
		end else begin
			periph[ln-21] <= v;
		end
	endtask : set_src

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(27346));
		inv = 20'($urandom());
		raw_pri = inv;
		raw_sec = inv;
		repeat (5) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		cyc(1);
		check("mask_rst", mask, 32'hFFFFFFFF);
		check("wmask_rst", wmask, 32'hFFFFFFFF);
		check("pend_rst", pend, 32'h00000000);
		em = 32'hFFFFFFFF;
		ew = 32'hFFFFFFFF;
		for (int i = 0; i < 6; i++) begin
			r = $urandom();
			pulse(2, r);
			em &= ~r;
			check("mask_clr", mask, em);
			r = $urandom();
			pulse(1, r);
			em |= r;
			check("mask_set", mask, em);
			r = $urandom();
			pulse(4, r);
			ew &= ~r;
			check("wmask_clr", wmask, ew);
			r = $urandom();
			pulse(3, r);
			ew |= r;
			check("wmask_set", wmask, ew);
		end
		pulse(2, 32'hFFFFFFFF);
		pulse(4, 32'hFFFFFFFF);
		// internal sources, level sensitive, no debounce
		for (int ln = 20; ln < 32; ln++) begin
			set_src(ln, 1'b1);
			wait_pend(ln, 1'b1, 8 * DV);
			cyc(1);
			check("irq_on", irq, 1'b1);
			check("wake_on", wake, 1'b1);
			set_src(ln, 1'b0);
			wait_pend(ln, 1'b0, 8 * DV);
		end
		// pad lines: primary wins, secondary only as fallback
		for (int ln = 0; ln < 20; ln++) begin
			@(posedge sys_clk_in);
			fsel_pri[3*ln+:3] <= PRI_SEL[ln];
			fsel_sec[3*ln+:3] <= SEC_SEL[ln];
			raw_sec[ln] <= ~inv[ln];
			cyc(6 * DV);
			check("pri_wins", pend[ln], 1'b0);
			set_src(ln, 1'b1);
			wait_pend(ln, 1'b1, 8 * DV);
			@(posedge sys_clk_in);
			fsel_pri[3*ln+:3] <= PRI_SEL[ln] ^ 3'h7;
			raw_pri[ln] <= inv[ln];
			cyc(6 * DV);
			check("sec_used", pend[ln], HAS_SEC[ln]);
			@(posedge sys_clk_in);
			raw_sec[ln] <= inv[ln];
			cyc(6 * DV);
		end
		// edge line acknowledge, level line ignores it
		@(posedge sys_clk_in);
		edge_s <= 32'h02000000;
		set_src(25, 1'b1);
		wait_pend(25, 1'b1, 8 * DV);
		pulse(0, 32'hFDFFFFFF);
		check("ack_zero", pend[25], 1'b1);
		pulse(0, 32'h02000000);
		check("ack_one", pend[25], 1'b0);
		cyc(4 * DV);
		check("ack_hold", pend[25], 1'b0);
		set_src(26, 1'b1);
		wait_pend(26, 1'b1, 8 * DV);
		pulse(0, 32'h04000000);
		check("ack_level", pend[26], 1'b1);
		pulse(1, 32'h04000000);
		cyc(1);
		check("irq_masked", irq, 1'b0);
		check("wake_open", wake, 1'b1);
		pulse(3, 32'h04000000);
		cyc(1);
		check("wake_masked", wake, 1'b0);
		@(posedge sys_clk_in);
		pol[26] <= 1'b1;
		cyc(3);
		check("pol_fast", pend[26], 1'b0);
		@(posedge sys_clk_in);
		db_en[27] <= 1'b1;
		cyc(3 * DV);
		set_src(27, 1'b1);
		cyc(DV);
		set_src(27, 1'b0);
		cyc(6 * DV);
		check("db_glitch", pend[27], 1'b0);
		set_src(27, 1'b1);
		cyc(PER * DV);
		check("db_early", pend[27], 1'b0);
		wait_pend(27, 1'b1, (PER + 6) * DV);
		set_src(27, 1'b0);
		cyc(PER * DV);
		check("db_hold", pend[27], 1'b1);
		wait_pend(27, 1'b0, (PER + 6) * DV);
		complete_run();
	end
endmodule : tb_top
